// ===== rtl/pas_pkg.sv
// Shared constants and types of the pipelined converter sample port
package pas_pkg;
   // Clock and timing
   localparam int CLK_PERIOD_NS   = 4;
   localparam int CONV_TIME_NS    = 70;
   localparam int CONV_CYCLES     = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REFRESH_TIME_US = 500;
   localparam int REFRESH_CYCLES  = REFRESH_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int REFRESH_CNT_W   = 17;
   localparam int CONV_CNT_W      = 5;

   // Widths and depths
   localparam int DATA_W     = 12;
   localparam int AIN_W      = 16;
   localparam int VREF_W     = 13;
   localparam int QUO_BITS   = 11;
   localparam int NUM_W      = 27;
   localparam int FIFO_DEPTH = 8;
   localparam int FILL_W     = 4;
   localparam int PIN_CNT    = 4;

   // Result of a sample leaves at the end of the third conversion
   localparam logic [FILL_W-1:0] PIPE_DEPTH = 4'h3;

   // Reference levels in millivolts
   localparam logic [VREF_W-1:0] VREF_INT_HI_MV = 13'h1000;
   localparam logic [VREF_W-1:0] VREF_INT_LO_MV = 13'h0800;

   // Reference strap encodings
   localparam logic [1:0] REF_SEL_GND  = 2'h0;
   localparam logic [1:0] REF_SEL_VREF = 2'h1;
   localparam logic [1:0] REF_SEL_VDD  = 2'h2;

   // Full-scale codes
   localparam logic [DATA_W-1:0] CODE_POS_FS = 12'h7ff;
   localparam logic [DATA_W-1:0] CODE_NEG_FS = 12'h800;

   // Synchroniser bit positions
   localparam int PIN_CONV = 0;
   localparam int PIN_GAIN = 1;
   localparam int PIN_REF0 = 2;

   typedef enum logic [1:0] {
      PAS_IDLE,
      PAS_DIVIDE,
      PAS_SETTLE,
      PAS_PUSH
   } pas_state_e;
endpackage : pas_pkg

// ===== rtl/pas_stream_if.sv
// Valid/ready word stream between the converter core and its buffer
interface pas_stream_if #(
   parameter int W = 12
) ();
   logic [W-1:0] data;   // Word
   logic         valid;  // Word offered
   logic         ready;  // Word taken

   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : pas_stream_if

// ===== rtl/pas_fifo.sv
// Result buffer: synchronous FIFO with flush
module pas_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 8
) (
   input wire logic   mclk,     // System clock
   input wire logic   reset_n,  // Async reset, active low
   input wire logic   flush,    // Drop all entries
   pas_stream_if.snk  wr,       // Fill side
   pas_stream_if.src  rd        // Drain side
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_ptr_q;
   logic [PW-1:0]    rd_ptr_q;
   logic [PW:0]      count_q;
   logic             push_w;
   logic             pop_w;

   // Honest flags: full stalls the writer
   assign wr.ready = (count_q < (PW+1)'(DEPTH));
   assign rd.valid = (count_q != '0);
   assign rd.data  = mem_q[rd_ptr_q];
   assign push_w   = wr.valid && wr.ready;
   assign pop_w    = rd.valid && rd.ready;

   // Storage
   always_ff @(posedge mclk) begin
      if (push_w) begin
         mem_q[wr_ptr_q] <= wr.data;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else if (flush) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         if (push_w) begin
            wr_ptr_q <= (wr_ptr_q == PW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop_w) begin
            rd_ptr_q <= (rd_ptr_q == PW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
         end
         count_q <= count_q + (PW+1)'(push_w) - (PW+1)'(pop_w);
      end
   end
endmodule : pas_fifo

// ===== rtl/pas_top.sv
// Digital side of a 12-bit pipelined sampling converter
//
// Function
// - A rising conversion clock edge starts a conversion only while idle; falling edges do nothing.
// - Each start samples both analog inputs at once; conversions run one at a time.
// - Outputs show a sample's result two starts later plus about 70 ns.
// - Result is a parallel 12-bit two's complement word.
// - Overflow high exactly for codes 7ff or 800, low otherwise.
// - Gain select high gives 1x span, low gives 2x gain, half span.
// - After 500 us without a rising edge an internal timer refreshes dynamic logic.
// - Reference strap: ground 4.096 V, reference pin 2.048 V, supply external.
// - A started conversion runs to completion; it cannot abort or restart.
// - Out-of-range input clamps the code to an extreme and sets overflow; an in-range 7ff code sets it too.
module pas_top
   import pas_pkg::*;
#(
   parameter int unsigned REFRESH_CYC = REFRESH_CYCLES  // Idle cycles before a refresh
) (
   input  wire logic                    mclk,           // System clock, 250 MHz
   input  wire logic                    reset_n,        // Async reset, active low
   input  wire logic                    conv_clk,       // Conversion start pin
   input  wire logic                    gain_sel,       // Gain strap, high = 1x
   input  wire logic [1:0]              ref_sel,        // Reference strap
   input  wire logic [VREF_W-1:0]       ext_vref_mv,    // External reference, mV
   input  wire logic signed [AIN_W-1:0] ain_pos,        // Positive input, 0.125 mV units
   input  wire logic signed [AIN_W-1:0] ain_neg,        // Negative input, 0.125 mV units
   output logic [DATA_W-1:0]            sample_data,    // Result word
   output logic                         overflow_flag,  // Result at full scale
   output logic                         refresh_pulse,  // Refresh event
   output logic                         conv_busy       // Conversion in progress
);
   // Full-scale decode of the result word, used by the overflow path only
   function automatic logic is_full_scale(input logic [DATA_W-1:0] code);
      is_full_scale = (code == CODE_POS_FS) || (code == CODE_NEG_FS);
   endfunction : is_full_scale

   pas_stream_if #(.W(DATA_W)) wr_if ();
   pas_stream_if #(.W(DATA_W)) rd_if ();

   logic [PIN_CNT-1:0]       pin_w;
   logic [PIN_CNT-1:0]       sync1_q;
   logic [PIN_CNT-1:0]       sync2_q;
   logic [PIN_CNT-1:0]       sync3_q;
   logic [PIN_CNT-1:0]       stable_q;
   logic                     rise_w;
   logic                     start_w;
   pas_state_e               state_q;
   logic [CONV_CNT_W-1:0]    cnt_q;
   logic [3:0]               step_q;
   logic [VREF_W-1:0]        vref_w;
   logic signed [AIN_W:0]    vin_w;
   logic [AIN_W:0]           abs_w;
   logic [NUM_W-1:0]         num_w;
   logic                     ovr_w;
   logic [NUM_W-1:0]         mag_q;
   logic [NUM_W-1:0]         den_q;
   logic [QUO_BITS-1:0]      quo_q;
   logic                     neg_q;
   logic                     ovr_q;
   logic [DATA_W-1:0]        code_w;
   logic                     done_q;
   logic                     pop_w;
   logic [FILL_W-1:0]        fill_q;
   logic [REFRESH_CNT_W-1:0] idle_q;
   logic                     refresh_w;
   logic [DATA_W-1:0]        sample_data_q;
   logic                     overflow_flag_q;
   logic                     refresh_pulse_q;
   logic                     conv_busy_q;

   assign pin_w = {ref_sel, gain_sel, conv_clk};

   // Three-stage synchronisers; a level counts once stages two and three agree
   // Reset low, the idle level of the start pin, so no false edge follows reset
   genvar gi;
   generate
      for (gi = 0; gi < PIN_CNT; gi++) begin : g_sync
         always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
               sync1_q[gi]  <= 1'b0;
               sync2_q[gi]  <= 1'b0;
               sync3_q[gi]  <= 1'b0;
               stable_q[gi] <= 1'b0;
            end else begin
               sync1_q[gi] <= pin_w[gi];
               sync2_q[gi] <= sync1_q[gi];
               sync3_q[gi] <= sync2_q[gi];
               if (sync2_q[gi] == sync3_q[gi]) begin
                  stable_q[gi] <= sync3_q[gi];
               end
            end
         end
      end
   endgenerate

   // Only the rising edge matters; falling edges are ignored
   assign rise_w  = sync2_q[PIN_CONV] && sync3_q[PIN_CONV] && !stable_q[PIN_CONV];
   // Edges during a running conversion are dropped, never restart it
   assign start_w = rise_w && (state_q == PAS_IDLE);

   // Reference selection from the strap
   always_comb begin
      case (stable_q[PIN_REF0 +: 2])
         REF_SEL_GND:  vref_w = VREF_INT_HI_MV;
         REF_SEL_VREF: vref_w = VREF_INT_LO_MV;
         default:      vref_w = ext_vref_mv;
      endcase
   end

   // Differential input, both legs taken in the same cycle
   assign vin_w = {ain_pos[AIN_W-1], ain_pos} - {ain_neg[AIN_W-1], ain_neg};
   assign abs_w = vin_w[AIN_W] ? (AIN_W+1)'(-vin_w) : vin_w;
   // 2x gain doubles the numerator, which halves the span
   assign num_w = stable_q[PIN_GAIN] ? {1'b0, abs_w, 9'h000} : {abs_w, 10'h000};
   assign ovr_w = num_w >= {3'h0, vref_w, 11'h000};

   // Conversion sequence
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= PAS_IDLE;
      end else begin
         case (state_q)
            PAS_IDLE: begin
               if (start_w) begin
                  state_q <= PAS_DIVIDE;
               end
            end
            PAS_DIVIDE: begin
               if (step_q == 4'(QUO_BITS-1)) begin
                  state_q <= PAS_SETTLE;
               end
            end
            PAS_SETTLE: begin
               if (cnt_q == CONV_CNT_W'(CONV_CYCLES-1)) begin
                  state_q <= PAS_PUSH;
               end
            end
            PAS_PUSH: begin
               if (wr_if.ready) begin
                  state_q <= PAS_IDLE;
               end
            end
            default: state_q <= PAS_IDLE;
         endcase
      end
   end

   // Conversion time counter
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= '0;
      end else if (start_w) begin
         cnt_q <= '0;
      end else if (state_q != PAS_IDLE && cnt_q != CONV_CNT_W'(CONV_CYCLES-1)) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // Restoring divider; one quotient bit per cycle keeps timing easy at 250 MHz
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         mag_q  <= '0;
         den_q  <= '0;
         quo_q  <= '0;
      end else if (start_w) begin
         mag_q  <= num_w;
         den_q  <= {4'h0, vref_w, 10'h000};
         quo_q  <= '0;
      end else if (state_q == PAS_DIVIDE) begin
         if (mag_q >= den_q) begin
            mag_q <= mag_q - den_q;
            quo_q <= {quo_q[QUO_BITS-2:0], 1'b1};
         end else begin
            quo_q <= {quo_q[QUO_BITS-2:0], 1'b0};
         end
         den_q  <= den_q >> 1;
      end
   end

   // Quotient bit position; the sequencer leaves the divide state on the last bit
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         step_q <= '0;
      end else if (start_w) begin
         step_q <= '0;
      end else if (state_q == PAS_DIVIDE) begin
         step_q <= step_q + 1'b1;
      end
   end

   // Sign and range are taken with the sample, so later input changes cannot split them
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         neg_q <= 1'b0;
         ovr_q <= 1'b0;
      end else if (start_w) begin
         neg_q <= vin_w[AIN_W];
         ovr_q <= ovr_w;
      end
   end

   // Out-of-range inputs clamp to an extreme code; else signed quotient
   always_comb begin
      if (ovr_q) begin
         code_w = neg_q ? CODE_NEG_FS : CODE_POS_FS;
      end else if (neg_q) begin
         code_w = DATA_W'(-{1'b0, quo_q});
      end else begin
         code_w = {1'b0, quo_q};
      end
   end

   assign wr_if.valid = (state_q == PAS_PUSH);
   assign wr_if.data  = code_w;

   // Finished results queue until two later conversions have completed
   pas_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .mclk    (mclk),
      .reset_n (reset_n),
      .flush   (refresh_w),
      .wr      (wr_if),
      .rd      (rd_if)
   );

   // Drain one result at each conversion end once three are held
   assign pop_w       = done_q && (fill_q >= PIPE_DEPTH) && rd_if.valid;
   assign rd_if.ready = pop_w;

   // End-of-conversion marker, one cycle after the push
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         done_q <= 1'b0;
      end else begin
         done_q <= wr_if.valid && wr_if.ready;
      end
   end

   // Queue occupancy; a refresh empties it together with the buffer
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         fill_q <= '0;
      end else if (refresh_w) begin
         fill_q <= '0;
      end else begin
         fill_q <= fill_q + FILL_W'(wr_if.valid && wr_if.ready) - FILL_W'(pop_w);
      end
   end

   // Output word and overflow update together
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sample_data_q   <= '0;
         overflow_flag_q <= 1'b0;
      end else if (pop_w) begin
         sample_data_q   <= rd_if.data;
         overflow_flag_q <= is_full_scale(rd_if.data);
      end
   end

   // Idle timer; refresh discards stale pipeline contents with no power cost
   // Any rising edge counts as activity, even one dropped while busy
   assign refresh_w = (idle_q == REFRESH_CNT_W'(REFRESH_CYC-1));
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         idle_q <= '0;
      end else if (rise_w || refresh_w) begin
         idle_q <= '0;
      end else begin
         idle_q <= idle_q + 1'b1;
      end
   end

   // Refresh event, one cycle per refresh
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         refresh_pulse_q <= 1'b0;
      end else begin
         refresh_pulse_q <= refresh_w;
      end
   end

   // Busy status
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         conv_busy_q <= 1'b0;
      end else begin
         conv_busy_q <= start_w || (state_q != PAS_IDLE && !(state_q == PAS_PUSH && wr_if.ready));
      end
   end

   assign sample_data   = sample_data_q;
   assign overflow_flag = overflow_flag_q;
   assign refresh_pulse = refresh_pulse_q;
   assign conv_busy     = conv_busy_q;
endmodule : pas_top

// ===== sim/pas_properties.sv
// Concurrent checks on the converter sample port pins
module pas_props
   import pas_pkg::*;
#(
   parameter int unsigned REFRESH_CYC = REFRESH_CYCLES  // Idle cycles before a refresh
) (
   input wire logic              mclk,           // System clock
   input wire logic              reset_n,        // Async reset, active low
   input wire logic              conv_clk,       // Conversion start pin
   input wire logic [DATA_W-1:0] sample_data,    // Result word
   input wire logic              overflow_flag,  // Result at full scale
   input wire logic              refresh_pulse,  // Refresh event
   input wire logic              conv_busy       // Conversion in progress
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [16:0] idle_q;

   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);

   // Quiet cycles since the last conversion; saturates so it never wraps back to zero
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         idle_q <= '0;
      end else if (conv_busy) begin
         idle_q <= '0;
      end else if (idle_q != 17'h1ffff) begin
         idle_q <= idle_q + 17'h00001;
      end
   end

   of_match_a:
      assert property (overflow_flag == (sample_data == CODE_POS_FS || sample_data == CODE_NEG_FS))
      else $error("overflow flag disagrees with result word");
   flag_align_a:
      assert property ($changed(overflow_flag) |-> $changed(sample_data))
      else $error("overflow flag moved without a new word");
   start_rise_a:
      assert property ($rose(conv_busy) |-> conv_clk && !$past(conv_clk, 6))
      else $error("conversion began without a rising start edge");
   busy_hold_a:
      assert property ($rose(conv_busy) |-> conv_busy [*8])
      else $error("conversion cut short");
   busy_end_a:
      assert property ($rose(conv_busy) |-> ##[10:30] !conv_busy)
      else $error("conversion did not finish in time");
   quiet_busy_a:
      assert property (conv_busy |-> $stable(sample_data))
      else $error("result word changed during a conversion");
   data_after_conv_a:
      assert property ($changed(sample_data) |-> !conv_busy && $past(conv_busy, 4))
      else $error("result word changed away from a conversion end");
   pulse_single_a:
      assert property (refresh_pulse |=> !refresh_pulse)
      else $error("refresh pulse longer than one cycle");
   refresh_idle_a:
      assert property (refresh_pulse |-> !conv_busy && int'(idle_q) + 40 > int'(REFRESH_CYC))
      else $error("refresh came too early");
endmodule : pas_props

bind pas_top pas_props #(.REFRESH_CYC(REFRESH_CYC)) u_props (
   .mclk          (mclk),
   .reset_n       (reset_n),
   .conv_clk      (conv_clk),
   .sample_data   (sample_data),
   .overflow_flag (overflow_flag),
   .refresh_pulse (refresh_pulse),
   .conv_busy     (conv_busy)
);

// ===== sim/pas_cap_model.sv
// Capture-side model: makes conversion clock periods and latches results
module pas_cap_model
   import pas_pkg::*;
(
   input  wire logic              mclk,      // System clock
   input  wire logic              reset_n,   // Reset, active low
   input  wire logic              go,        // Start one period
   input  wire logic [DATA_W-1:0] din,       // Result word
   input  wire logic              ovf,       // Overflow flag
   output logic                   conv_clk,  // Conversion clock
   output logic                   done,      // Period over
   output logic [DATA_W-1:0]      cap_data,  // Word latched at a rise
   output logic                   cap_ovf,   // Flag latched with it
   output logic [DATA_W-1:0]      cap_ofs    // Offset binary view
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [4:0] cnt_q;

   // Offset binary by flipping the top bit
   assign cap_ofs = {~cap_data[DATA_W-1], cap_data[DATA_W-2:0]};

   // 12 high, 13 low: inside 10 MHz, far above 20 kHz; pin stays low while idle
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         conv_clk <= 1'b0;
         done     <= 1'b0;
         cnt_q    <= 5'h00;
         cap_data <= '0;
         cap_ovf  <= 1'b0;
      end else begin
         done <= (cnt_q == 5'h18);
         if (go && cnt_q == 5'h00) begin
            conv_clk <= 1'b1;
            cap_data <= din;
            cap_ovf  <= ovf;
            cnt_q    <= 5'h01;
         end else if (cnt_q != 5'h00) begin
            cnt_q <= (cnt_q == 5'h18) ? 5'h00 : cnt_q + 5'h01;
            if (cnt_q == 5'h0c) begin
               conv_clk <= 1'b0;
            end
         end
      end
   end
endmodule : pas_cap_model

// ===== sim/tb.sv
// Self-checking bench for the converter sample port
module tb
   import pas_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [AIN_W-1:0]  pos;
      logic [AIN_W-1:0]  neg;
      logic              gain;
      logic [1:0]        rsel;
      logic [DATA_W-1:0] code;
      logic              ovf;
   } pas_row_s;

   localparam int NR = 12;
   // Inputs beside the word and flag they should give; external reference is 1000 mV
   localparam pas_row_s ROWS [NR] = '{
      '{16'h0000, 16'h0000, 1'b1, 2'h0, 12'h000, 1'b0}, '{16'h0008, 16'h0000, 1'b1, 2'h0, 12'h001, 1'b0},
      '{16'h0000, 16'h0008, 1'b1, 2'h0, 12'hfff, 1'b0}, '{16'h3ff8, 16'h0000, 1'b1, 2'h0, 12'h7ff, 1'b1},
      '{16'h3ff0, 16'h0000, 1'b1, 2'h0, 12'h7fe, 1'b0}, '{16'hc000, 16'h0000, 1'b1, 2'h0, 12'h800, 1'b1},
      '{16'h4e20, 16'h0000, 1'b1, 2'h0, 12'h7ff, 1'b1}, '{16'h0028, 16'h0000, 1'b0, 2'h0, 12'h00a, 1'b0},
      '{16'h2000, 16'h0000, 1'b0, 2'h0, 12'h7ff, 1'b1}, '{16'h0018, 16'h0000, 1'b1, 2'h1, 12'h006, 1'b0},
      '{16'h03e8, 16'h0000, 1'b1, 2'h2, 12'h200, 1'b0}, '{16'hfc18, 16'h0000, 1'b1, 2'h3, 12'he00, 1'b0}
   };

   logic              mclk     = 1'b0;
   logic              reset_n  = 1'b0;
   logic              go       = 1'b0;
   logic              gain_sel = 1'b1;
   logic [1:0]        ref_sel  = 2'h0;
   logic [AIN_W-1:0]  ain_pos  = '0;
   logic [AIN_W-1:0]  ain_neg  = '0;
   logic              conv_clk, done, overflow_flag, refresh_pulse, conv_busy, cap_ovf;
   logic [DATA_W-1:0] sample_data, cap_data, cap_ofs;
   int                n_errors = 0;
   int                n_tests  = 0;
   int                n_ref    = 0;

   pas_top #(.REFRESH_CYC(200)) dut (
      .mclk          (mclk),
      .reset_n       (reset_n),
      .conv_clk      (conv_clk),
      .gain_sel      (gain_sel),
      .ref_sel       (ref_sel),
      .ext_vref_mv   (13'h03e8),
      .ain_pos       (ain_pos),
      .ain_neg       (ain_neg),
      .sample_data   (sample_data),
      .overflow_flag (overflow_flag),
      .refresh_pulse (refresh_pulse),
      .conv_busy     (conv_busy)
   );

   pas_cap_model host (
      .mclk     (mclk),
      .reset_n  (reset_n),
      .go       (go),
      .din      (sample_data),
      .ovf      (overflow_flag),
      .conv_clk (conv_clk),
      .done     (done),
      .cap_data (cap_data),
      .cap_ovf  (cap_ovf),
      .cap_ofs  (cap_ofs)
   );

   // 250 MHz clock
   always #2 mclk = ~mclk;

   // Count refresh events seen on the pin
   always @(posedge mclk) begin
      if (refresh_pulse === 1'b1) begin
         n_ref <= n_ref + 1;
      end
   end

   task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Set straps and inputs, then one conversion clock period; inputs hold for the whole period
   task automatic pulse(input pas_row_s r);
      ain_pos  <= r.pos;
      ain_neg  <= r.neg;
      gain_sel <= r.gain;
      ref_sel  <= r.rsel;
      go       <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      for (int w = 0; w < 40 && done !== 1'b1; w++) @(posedge mclk);
   endtask : pulse

   task automatic end_sim();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_sim

   // Watchdog: the sequence needs about 740 cycles
   initial begin
      repeat (2000) @(posedge mclk);
      n_errors++;
      $display("CHECK FAILED watchdog expected finish seen hang");
      end_sim();
   end

   // Table rows, then refresh and flush by hand
   initial begin
      repeat (5) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (5) @(posedge mclk);
      chk("reset data", 12'h000, sample_data);
      chk("reset flags", 12'h000, {9'h000, overflow_flag, refresh_pulse, conv_busy});
      // Trailing pulses use distinct rows so the words flushed by the refresh differ from the output
      for (int j = 0; j < NR + 3; j++) begin
         pulse(ROWS[j % NR]);
         if (j >= 3) begin
            chk("data", ROWS[j-3].code, cap_data);
            chk("overflow", {11'h000, ROWS[j-3].ovf}, {11'h000, cap_ovf});
            chk("offset", {~ROWS[j-3].code[11], ROWS[j-3].code[10:0]}, cap_ofs);
         end
      end
      repeat (260) @(posedge mclk);
      chk("refresh count", 12'h001, n_ref[11:0]);
      pulse(ROWS[6]);
      pulse(ROWS[6]);
      repeat (2) @(posedge mclk);
      chk("flushed data", 12'h000, sample_data);
      pulse(ROWS[6]);
      repeat (2) @(posedge mclk);
      chk("data after refresh", 12'h7ff, sample_data);
      end_sim();
   end
endmodule : tb
